// File: eight_bit_pwm_map.vh
`ifndef EIGHT_BIT_PWM_MAP_VH
`define EIGHT_BIT_PWM_MAP_VH
// Register byte offsets
`define UNIT0_MODE_OFS 8'h00
`define UNIT0_PERIOD_OFS 8'h04
`define UNIT0_DUTY_OFS 8'h08
`define UNIT1_MODE_OFS 8'h0c
`define UNIT1_PERIOD_OFS 8'h10
`define UNIT1_DUTY_OFS 8'h14
`define CARRIER_CTRL_OFS 8'h18
`define EVENT_MODE_OFS 8'h1c
`define EVENT_COMPARE_OFS 8'h20
`define IRQ_STATUS_OFS 8'h24
`define IRQ_MASK_OFS 8'h28
`define COUNT_VIEW_OFS 8'h2c
// Mode register fields
`define MODE_RUN_BIT 7
`define MODE_CKS_HI 6
`define MODE_CKS_LO 4
`define MODE_SEL_HI 3
`define MODE_SEL_LO 2
// Operating modes
`define MODE_INTERVAL 2'h0
`define MODE_PWM 2'h1
`define MODE_CARRIER 2'h2
// Carrier control fields
`define CAR_BUFFER_BIT 0
`define CAR_LEVEL_BIT 1
`define CAR_OUTPUT_BIT 2
// Status bits
`define IRQ_UNIT0_BIT 0
`define IRQ_UNIT1_BIT 1
`define IRQ_EVENT_BIT 2
// Reset values
`define RESET_BYTE 8'h00
`define RESET_PERIOD 8'hff
// Count clocks before a new duty value is used
`define DUTY_TRANSFER_TICKS 2'h3
// Clock select code for internal oscillator divided by 128
`define CKS_OSC_DIV128 3'h5
`endif

// File: timer_unit.v
`timescale 1ns/10ps
`default_nettype none
`include "eight_bit_pwm_map.vh"
module timer_unit (
	input wire clock,
	input wire nrst,
	input wire countTick,
	input wire run,
	input wire [1:0] mode,
	input wire [7:0] period,
	input wire [7:0] duty,
	input wire dutyWritten,
	output reg [7:0] count,
	output reg timerOut,
	output reg periodMatch
);
	reg [7:0] workingDuty;
	reg [1:0] transferCount;
	reg transferPending;
	reg carrierHigh;
	wire [7:0] target;

	// Duty value moves to the compare stage after three count clocks
	always @(posedge clock) begin
		if (!nrst) begin
			workingDuty <= `RESET_BYTE;
			transferCount <= 2'h0;
			transferPending <= 1'b0;
		end else if (dutyWritten) begin
			transferPending <= 1'b1;
			transferCount <= 2'h0;
		end else if (transferPending && countTick) begin
			if (transferCount == `DUTY_TRANSFER_TICKS - 2'h1) begin
				workingDuty <= duty;
				transferPending <= 1'b0;
			end
			transferCount <= transferCount + 2'h1;
		end
	end

	// Carrier mode counts the low phase to period, the high phase to duty
	assign target = (mode == `MODE_CARRIER && carrierHigh) ? workingDuty : period;

	// Counter, compare and output
	always @(posedge clock) begin
		if (!nrst) begin
			count <= 8'h00;
			timerOut <= 1'b0;
			carrierHigh <= 1'b0;
			periodMatch <= 1'b0;
		end else if (!run) begin
			count <= 8'h00;
			timerOut <= 1'b0;
			carrierHigh <= 1'b0;
			periodMatch <= 1'b0;
		end else begin
			periodMatch <= 1'b0;
			if (countTick) begin
				if (count == target) begin
					count <= 8'h00;
					periodMatch <= ~(mode == `MODE_CARRIER && carrierHigh);
					case (mode)
						`MODE_PWM: timerOut <= 1'b1;
						`MODE_CARRIER: begin
							carrierHigh <= ~carrierHigh;
							timerOut <= ~carrierHigh;
						end
						default: timerOut <= ~timerOut;
					endcase
				end else begin
					count <= count + 8'h01;
					if (mode == `MODE_PWM && count == workingDuty)
						timerOut <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: pwm_carrier_timer.v
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "eight_bit_pwm_map.vh"
module pwm_carrier_timer (
	input wire clock,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire oscPin,
	output reg irq,
	output reg firstUnitOut,
	output reg secondUnitOut,
	output reg carrierPin
);
	reg [7:0] firstUnitMode;
	reg [7:0] firstUnitPeriod;
	reg [7:0] firstUnitDuty;
	reg [7:0] secondUnitMode;
	reg [7:0] secondUnitPeriod;
	reg [7:0] secondUnitDuty;
	reg [7:0] eventMode;
	reg [7:0] eventCompare;
	reg [7:0] eventCount;
	reg carrierBuffer;
	reg remoteLevel;
	reg carrierOutput;
	reg [2:0] status;
	reg [2:0] mask;
	reg [9:0] prescale;
	reg [9:0] prescaleLast;
	reg [2:0] oscSync;
	reg oscLevel;
	reg [6:0] oscDivide;
	reg oscDivLast;
	reg [2:0] next_status;
	reg [31:0] readData;
	wire access;
	wire writeDone;
	wire readDone;
	wire [9:0] risen;
	wire oscTick128;
	wire firstTick;
	wire secondTick;
	wire eventTick;
	wire [7:0] count0;
	wire [7:0] count1;
	wire out0;
	wire out1;
	wire match0;
	wire match1;
	reg eventMatch;
	wire carrierMode;

	// Count clock choice from the divider taps; code 101 uses the oscillator
	function selectTick;
		input [2:0] code;
		input [9:0] taps;
		input oscTap;
		begin
			case (code)
				3'h0: selectTick = taps[0];
				3'h1: selectTick = taps[1];
				3'h2: selectTick = taps[3];
				3'h3: selectTick = taps[5];
				3'h4: selectTick = taps[7];
				3'h5: selectTick = oscTap;
				3'h6: selectTick = taps[8];
				default: selectTick = taps[9];
			endcase
		end
	endfunction

	// APB handshake: one wait cycle, transfer completes when pready is high
	assign access = psel && penable;
	assign writeDone = access && pready && pwrite;
	assign readDone = access && pready && !pwrite;
	assign carrierMode = secondUnitMode[`MODE_SEL_HI:`MODE_SEL_LO] == `MODE_CARRIER;

	// System clock prescaler; a tap edge is one system cycle wide
	always @(posedge clock) begin
		if (!nrst) begin
			prescale <= 10'h000;
			prescaleLast <= 10'h000;
		end else begin
			prescale <= prescale + 10'h001;
			prescaleLast <= prescale;
		end
	end
	assign risen = prescale & ~prescaleLast;

	// Oscillator pin passes three flops; a change counts when the last two agree
	always @(posedge clock) begin
		if (!nrst) begin
			oscSync <= 3'h0;
			oscLevel <= 1'b0;
			oscDivide <= 7'h00;
			oscDivLast <= 1'b0;
		end else begin
			oscSync <= {oscSync[1:0], oscPin};
			if (oscSync[2] == oscSync[1])
				oscLevel <= oscSync[2];
			if (oscSync[2] == oscSync[1] && oscSync[2] && !oscLevel)
				oscDivide <= oscDivide + 7'h01;
			oscDivLast <= oscDivide[6];
		end
	end
	assign oscTick128 = oscDivide[6] && !oscDivLast;

	assign firstTick = selectTick(firstUnitMode[`MODE_CKS_HI:`MODE_CKS_LO], risen, oscTick128);
	assign secondTick = selectTick(secondUnitMode[`MODE_CKS_HI:`MODE_CKS_LO], risen, oscTick128);
	assign eventTick = selectTick(eventMode[`MODE_CKS_HI:`MODE_CKS_LO], risen, oscTick128);

	timer_unit firstUnit (
		.clock(clock),
		.nrst(nrst),
		.countTick(firstTick),
		.run(firstUnitMode[`MODE_RUN_BIT]),
		.mode(firstUnitMode[`MODE_SEL_HI:`MODE_SEL_LO]),
		.period(firstUnitPeriod),
		.duty(firstUnitDuty),
		.dutyWritten(writeDone && paddr == `UNIT0_DUTY_OFS),
		.count(count0),
		.timerOut(out0),
		.periodMatch(match0)
	);

	timer_unit secondUnit (
		.clock(clock),
		.nrst(nrst),
		.countTick(secondTick),
		.run(secondUnitMode[`MODE_RUN_BIT]),
		.mode(secondUnitMode[`MODE_SEL_HI:`MODE_SEL_LO]),
		.period(secondUnitPeriod),
		.duty(secondUnitDuty),
		.dutyWritten(writeDone && paddr == `UNIT1_DUTY_OFS),
		.count(count1),
		.timerOut(out1),
		.periodMatch(match1)
	);

	// Companion event counter; its match latches the buffer bit in carrier mode and interrupts
	always @(posedge clock) begin
		if (!nrst) begin
			eventCount <= 8'h00;
			eventMatch <= 1'b0;
			carrierOutput <= 1'b0;
		end else begin
			eventMatch <= 1'b0;
			if (!eventMode[`MODE_RUN_BIT]) begin
				eventCount <= 8'h00;
			end else if (eventTick) begin
				if (eventCount == eventCompare) begin
					eventCount <= 8'h00;
					eventMatch <= 1'b1;
					if (carrierMode)
						carrierOutput <= carrierBuffer;
				end else begin
					eventCount <= eventCount + 8'h01;
				end
			end
		end
	end

	// Register writes
	always @(posedge clock) begin
		if (!nrst) begin
			firstUnitMode <= `RESET_BYTE;
			firstUnitPeriod <= `RESET_PERIOD;
			firstUnitDuty <= `RESET_BYTE;
			secondUnitMode <= `RESET_BYTE;
			secondUnitPeriod <= `RESET_PERIOD;
			secondUnitDuty <= `RESET_BYTE;
			eventMode <= `RESET_BYTE;
			eventCompare <= `RESET_PERIOD;
			carrierBuffer <= 1'b0;
			remoteLevel <= 1'b0;
			mask <= 3'h0;
		end else if (writeDone) begin
			case (paddr)
				`UNIT0_MODE_OFS: firstUnitMode <= pwdata[7:0];
				`UNIT0_PERIOD_OFS: firstUnitPeriod <= pwdata[7:0];
				`UNIT0_DUTY_OFS: firstUnitDuty <= pwdata[7:0];
				`UNIT1_MODE_OFS: secondUnitMode <= pwdata[7:0];
				`UNIT1_PERIOD_OFS: secondUnitPeriod <= pwdata[7:0];
				`UNIT1_DUTY_OFS: secondUnitDuty <= pwdata[7:0];
				`CARRIER_CTRL_OFS: begin
					carrierBuffer <= pwdata[`CAR_BUFFER_BIT];
					remoteLevel <= pwdata[`CAR_LEVEL_BIT];
				end
				`EVENT_MODE_OFS: eventMode <= pwdata[7:0];
				`EVENT_COMPARE_OFS: eventCompare <= pwdata[7:0];
				`IRQ_MASK_OFS: mask <= pwdata[2:0];
				default: mask <= mask;
			endcase
		end
	end

	// Read mux; unmapped addresses read zero
	always @* begin
		readData = 32'h00000000;
		case (paddr)
			`UNIT0_MODE_OFS: readData[7:0] = firstUnitMode;
			`UNIT0_PERIOD_OFS: readData[7:0] = firstUnitPeriod;
			`UNIT0_DUTY_OFS: readData[7:0] = firstUnitDuty;
			`UNIT1_MODE_OFS: readData[7:0] = secondUnitMode;
			`UNIT1_PERIOD_OFS: readData[7:0] = secondUnitPeriod;
			`UNIT1_DUTY_OFS: readData[7:0] = secondUnitDuty;
			`CARRIER_CTRL_OFS: readData[2:0] = {carrierOutput, remoteLevel, carrierBuffer};
			`EVENT_MODE_OFS: readData[7:0] = eventMode;
			`EVENT_COMPARE_OFS: readData[7:0] = eventCompare;
			`IRQ_STATUS_OFS: readData[2:0] = status;
			`IRQ_MASK_OFS: readData[2:0] = mask;
			`COUNT_VIEW_OFS: readData[23:0] = {eventCount, count1, count0};
			default: readData = 32'h00000000;
		endcase
	end

	// Sticky status; read clears, a new event in the same cycle wins
	always @* begin
		next_status = status;
		if (readDone && paddr == `IRQ_STATUS_OFS)
			next_status = 3'h0;
		if (match0)
			next_status[`IRQ_UNIT0_BIT] = 1'b1;
		if (match1)
			next_status[`IRQ_UNIT1_BIT] = 1'b1;
		if (eventMatch)
			next_status[`IRQ_EVENT_BIT] = 1'b1;
	end

	// Bus answer, interrupt and pin registers
	always @(posedge clock) begin
		if (!nrst) begin
			status <= 3'h0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			irq <= 1'b0;
			firstUnitOut <= 1'b0;
			secondUnitOut <= 1'b0;
			carrierPin <= 1'b0;
		end else begin
			status <= next_status;
			pready <= access && !pready;
			pslverr <= 1'b0;
			if (access && !pready && !pwrite)
				prdata <= readData;
			irq <= |(next_status & mask);
			firstUnitOut <= out0;
			secondUnitOut <= out1;
			// Carrier gated by the output bit; level bit sets active polarity
			carrierPin <= carrierMode ? ((carrierOutput & out1) ^ ~remoteLevel) : 1'b0;
		end
	end
endmodule
`default_nettype wire

// File: osc_source.sv
`timescale 1ns/10ps
`default_nettype none
// Free-running internal oscillator fed to the block as a pin
module osc_source #(parameter int HALF = 80) (
	output logic oscPin
);
	// Offset keeps pin edges off the sampling edge; each phase spans two samples
	initial begin
		oscPin = 1'b0;
		#7;
		forever #HALF oscPin = ~oscPin;
	end
endmodule
`default_nettype wire

// File: pwm_carrier_timer_props.sv
`timescale 1ns/10ps
`default_nettype none
module pwm_carrier_timer_props (
	input wire logic clock,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic firstUnitOut,
	input wire logic carrierPin
);
	logic [7:0] mode0, mode1;
	logic [2:0] mask;
	logic [3:0] since;
	wire wr = psel && penable && pready && pwrite;
	// Shadow of bus writes; since counts edges after the last write
	always_ff @(posedge clock)
		if (!nrst) begin
			mode0 <= 8'h00;
			mode1 <= 8'h00;
			mask <= 3'h0;
			since <= 4'h0;
		end else begin
			since <= wr ? 4'h0 : since + {3'h0, since != 4'hf};
			if (wr && paddr == 8'h00) mode0 <= pwdata[7:0];
			if (wr && paddr == 8'h0c) mode1 <= pwdata[7:0];
			if (wr && paddr == 8'h28) mask <= pwdata[2:0];
		end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	a_ready_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("ready not after one wait");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready too long");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_no_error: assert property (!pslverr)
		else $error("error response");
	a_read_hold: assert property ($changed(prdata) |-> pready && !pwrite)
		else $error("read data moved");
	a_irq_masked: assert property (since > 4'h3 && mask == 3'h0 |-> !irq)
		else $error("masked interrupt");
	a_unit_stopped: assert property (since > 4'h3 && !mode0[7] |=> $stable(firstUnitOut))
		else $error("stopped unit output moved");
	a_carrier_idle: assert property (since > 4'h3 && mode1[3:2] != 2'h2 |-> !carrierPin)
		else $error("carrier outside carrier mode");
endmodule
bind pwm_carrier_timer pwm_carrier_timer_props chk (.clock(clock), .nrst(nrst), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .firstUnitOut(firstUnitOut),
	.carrierPin(carrierPin));
`default_nettype wire

// File: eight_bit_pwm_carrier_timer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module eight_bit_pwm_carrier_timer_bench;
	logic clock, nrst, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	wire [31:0] prdata;
	wire pready, pslverr, oscPin, irq, firstUnitOut, secondUnitOut, carrierPin;
	logic [31:0] expQ[$];
	localparam logic [12:0] FF_MAP = 13'h112;
	// Count clock code 0 advances the units every second system clock
	localparam int TICK = 2;
	logic [1:0] pick;
	wire watched = pick == 2'h2 ? carrierPin : (pick == 2'h1 ? secondUnitOut : firstUnitOut);
	localparam logic [7:0] RW_ADDR [4] = '{8'h10, 8'h14, 8'h20, 8'h30};
	int checked = 0, mismatches = 0, hi, per, n, p, d;
	time t0;
	pwm_carrier_timer DUT (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .oscPin(oscPin), .irq(irq), .firstUnitOut(firstUnitOut),
		.secondUnitOut(secondUnitOut), .carrierPin(carrierPin));
	osc_source osc (.oscPin(oscPin));
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// One transfer: setup, access until ready is sampled, release, one idle edge
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= v;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask
	// High time and period of the watched output, in clock cycles
	task automatic measure();
		@(posedge watched);
		t0 = $time;
		@(negedge watched);
		hi = int'(($time - t0) / 40);
		@(posedge watched);
		per = int'(($time - t0) / 40);
	endtask
	task automatic waitIrq(input int lim);
		n = 0;
		while (irq !== 1'b1 && n < lim) begin
			@(posedge clock);
			n++;
		end
	endtask
	// Each completed read is compared with the oldest noted value
	always @(posedge clock)
		if (psel && penable && pready === 1'b1 && !pwrite)
			check(prdata, expQ.pop_front());
	initial begin
		#600000;
		mismatches++;
		summarize();
	end
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pick = 2'h0;
		void'($urandom(32'hbb001d66));
		repeat (2) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 13; i++)
			rd(8'(i * 4), FF_MAP[i] ? 32'hff : 32'h0);
		$display("reset values done");
		for (int i = 0; i < 8; i++) begin
			d = $urandom;
			bus(RW_ADDR[i % 4], 1'b1, 32'(d));
			rd(RW_ADDR[i % 4], i % 4 == 3 ? 32'h0 : {24'h0, d[7:0]});
		end
		$display("read back done");
		p = $urandom_range(40, 8);
		bus(8'h04, 1'b1, 32'(p));
		for (int k = 0; k < 2; k++) begin
			d = $urandom_range(p - 1, 0);
			bus(8'h08, 1'b1, 32'(d));
			if (k == 0) bus(8'h00, 1'b1, 32'h84);
			measure();
			measure();
			check(32'(hi), 32'(TICK * (d + 1)));
			check(32'(per), 32'(TICK * (p + 1)));
		end
		$display("pwm done");
		bus(8'h28, 1'b1, 32'h1);
		waitIrq(200);
		check(32'(irq), 32'h1);
		bus(8'h28, 1'b1, 32'h0);
		repeat (3) @(posedge clock);
		check(32'(irq), 32'h0);
		bus(8'h00, 1'b1, 32'h04);
		rd(8'h24, 32'h1);
		rd(8'h24, 32'h0);
		bus(8'h28, 1'b1, 32'h7);
		repeat (3) @(posedge clock);
		check(32'(irq), 32'h0);
		$display("interrupt done");
		bus(8'h10, 1'b1, 32'h3);
		bus(8'h0c, 1'b1, 32'hd0);
		waitIrq(2500);
		check(32'(n >= 800 && n < 2500), 32'h1);
		bus(8'h0c, 1'b1, 32'h50);
		rd(8'h24, 32'h2);
		$display("oscillator clock done");
		// Carrier on the second unit, gated by the companion counter
		pick = 2'h1;
		p = $urandom_range(8, 1);
		bus(8'h10, 1'b1, 32'(p));
		bus(8'h18, 1'b1, 32'h3);
		bus(8'h20, 1'b1, 32'h0);
		bus(8'h1c, 1'b1, 32'hc0);
		for (int k = 0; k < 2; k++) begin
			d = $urandom_range(8, 1);
			bus(8'h14, 1'b1, 32'(d));
			if (k == 0) bus(8'h0c, 1'b1, 32'h88);
			measure();
			measure();
			check(32'(hi), 32'(TICK * (d + 1)));
			check(32'(per), 32'(TICK * (p + d + 2)));
		end
		bus(8'h28, 1'b1, 32'h4);
		waitIrq(600);
		check(32'(irq), 32'h1);
		// Buffer bit set and level high: the pin follows the carrier
		pick = 2'h2;
		measure();
		measure();
		check(32'(hi), 32'(TICK * (d + 1)));
		check(32'(per), 32'(TICK * (p + d + 2)));
		// Buffer bit cleared: after the next counter match the pin stays low
		bus(8'h18, 1'b1, 32'h2);
		repeat (600) @(posedge clock);
		n = 0;
		repeat (40) begin
			@(posedge clock);
			if (carrierPin !== 1'b0) n++;
		end
		check(32'(n), 32'h0);
		// Level low while stopped: the idle pin inverts to high
		bus(8'h0c, 1'b1, 32'h08);
		bus(8'h18, 1'b1, 32'h0);
		n = 0;
		repeat (40) begin
			@(posedge clock);
			if (carrierPin !== 1'b1) n++;
		end
		check(32'(n), 32'h0);
		rd(8'h24, 32'h6);
		$display("carrier done");
		summarize();
	end
endmodule
`default_nettype wire
